// ### pkg/hcwv_pkg.sv
// Shared constants and types of the host CRC, watchdog and version block
package hcwv_pkg;

  // ***********************************************************************
  // Register byte addresses
  // ***********************************************************************
  localparam logic [15:0] ADDR_VERSION_LO = 16'hFFEE;
  localparam logic [15:0] ADDR_VERSION_HI = 16'hFFEF;
  localparam logic [15:0] ADDR_WD_LO      = 16'hFFF0;
  localparam logic [15:0] ADDR_WD_HI      = 16'hFFF1;
  localparam logic [15:0] ADDR_START_LO   = 16'hFFF2;
  localparam logic [15:0] ADDR_START_HI   = 16'hFFF3;
  localparam logic [15:0] ADDR_LEN_LO     = 16'hFFF4;
  localparam logic [15:0] ADDR_LEN_HI     = 16'hFFF5;
  localparam logic [15:0] ADDR_RESULT_LO  = 16'hFFF6;
  localparam logic [15:0] ADDR_RESULT_HI  = 16'hFFF7;

  // ***********************************************************************
  // Field positions and reset values
  // ***********************************************************************
  localparam int          WD_EN_BIT      = 0;
  localparam int          WD_SEL_LSB     = 1;
  localparam int          WD_SEL_MSB     = 3;
  localparam logic [3:0]  WD_CTL_RESET   = 4'h0;
  localparam logic [15:0] WORD_RESET     = 16'h0000;
  localparam logic [2:0]  WD_SEL_SHORT   = 3'h0;
  localparam logic [2:0]  WD_SEL_MEDIUM  = 3'h1;
  localparam logic [2:0]  WD_SEL_LONG    = 3'h2;

  // ***********************************************************************
  // Checksum constants
  // ***********************************************************************
  localparam logic [15:0] CRC_POLY       = 16'h1021;
  localparam logic [15:0] CRC_PRESET     = 16'hFFFF;

  // ***********************************************************************
  // Watchdog timing, counted in low-frequency oscillator periods
  // ***********************************************************************
  localparam int unsigned LFO_HZ         = 256000;
  localparam int unsigned WD_PERIOD0_MS  = 2000;
  localparam int unsigned WD_PERIOD1_MS  = 32000;
  localparam int unsigned WD_PERIOD2_MS  = 510000;
  localparam int unsigned WD_TICKS0      = WD_PERIOD0_MS * (LFO_HZ / 1000);
  localparam int unsigned WD_TICKS1      = WD_PERIOD1_MS * (LFO_HZ / 1000);
  localparam int unsigned WD_TICKS2      = WD_PERIOD2_MS * (LFO_HZ / 1000);
  localparam int          WD_CNT_W       = 28;

  typedef enum logic [1:0] {
    CRC_IDLE  = 2'b00,
    CRC_FETCH = 2'b01,
    CRC_ACCUM = 2'b10
  } hcwv_crc_state_e;

endpackage

// ### pkg/hcwv_crc_if.sv
// Carrier between the checksum sequencer and its byte update engine
`timescale 1ns/1ps
interface hcwv_crc_if;
  logic [7:0]  dataByte;
  logic [15:0] crcIn;
  logic [15:0] crcOut;

  modport engine (input dataByte, input crcIn, output crcOut);
  modport user   (output dataByte, output crcIn, input crcOut);
endinterface

// ### logic/hcwv_crc_byte.sv
// One-byte CRC-CCITT update, most significant bit first
`timescale 1ns/1ps
module hcwv_crc_byte
  import hcwv_pkg::*;
(
  hcwv_crc_if.engine bus
);

  // ***********************************************************************
  // Eight serial shift steps folded into one combinational pass
  // ***********************************************************************
  always_comb begin
    logic [15:0] c;
    logic        fb;
    c  = bus.crcIn;
    fb = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      fb = c[15] ^ bus.dataByte[i];
      c  = {c[14:0], 1'b0} ^ (fb ? CRC_POLY : WORD_RESET);
    end
    bus.crcOut = c;
  end

endmodule

// ### logic/hcwv_top.sv
// Host register functions: checksum engine, link watchdog, version word
`timescale 1ns/1ps
// Overview of operation
// - Checksum start location is forced even; bit zero is ignored.
// - Checksum is CRC-CCITT 0x1021, preset to all ones.
// - Enabled watchdog resets the device unless the host accesses in time.
// - In parity mode only transfers passing parity restart the watchdog.
// - Control bit 0 enables the watchdog; read/write, resets to zero.
// - Bits 3:1 pick 2 s, 32 s or 8.5 min; other codes reserved.
// - Read-only version word: low byte identity, high byte revision.
// - Writing the length high byte while idle starts a checksum run over the range.
// - Run end pulses crcDone for one cycle and loads the result register.
module hcwv_top #(
  parameter logic [7:0]  FW_ID        = 8'h5A, // Arbitrary identity value
  parameter logic [7:0]  FW_REV       = 8'h03, // Arbitrary revision value
  parameter int unsigned WD_TICKS_2S  = hcwv_pkg::WD_TICKS0,
  parameter int unsigned WD_TICKS_32S = hcwv_pkg::WD_TICKS1,
  parameter int unsigned WD_TICKS_8M  = hcwv_pkg::WD_TICKS2
) (
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic [15:0] regAddr,
  input  wire logic [7:0]  regWrData,
  input  wire logic        regWrEn,
  input  wire logic        regRdEn,
  output logic      [7:0]  regRdData,
  output logic             regRdValid,
  input  wire logic        xferDone,
  input  wire logic        xferParityOk,
  input  wire logic        byteParityCheckMode,
  input  wire logic        lfOscPin,
  output logic      [15:0] memAddr,
  output logic             memRdEn,
  input  wire logic [7:0]  memRdData,
  output logic             crcActive,
  output logic             crcDone,
  output logic             watchdogReset
);
  import hcwv_pkg::*;

  // ***********************************************************************
  // State
  // ***********************************************************************
  hcwv_crc_state_e      crcState_reg, crcState_next;
  logic [15:0]          startAddr_reg, startAddr_next;
  logic [15:0]          crcLen_reg, crcLen_next;
  logic [15:0]          crcResult_reg, crcResult_next;
  logic [15:0]          crcRun_reg, crcRun_next;
  logic [15:0]          bytesLeft_reg, bytesLeft_next;
  logic [15:0]          memAddr_reg, memAddr_next;
  logic                 memRdEn_reg, memRdEn_next;
  logic                 crcActive_reg, crcActive_next;
  logic                 crcDone_reg, crcDone_next;
  logic [3:0]           wdCtl_reg, wdCtl_next;
  logic [WD_CNT_W-1:0]  wdCount_reg, wdCount_next;
  logic                 wdReset_reg, wdReset_next;
  logic [7:0]           rdData_reg, rdData_next;
  logic                 rdValid_reg, rdValid_next;
  logic [2:0]           oscSync_reg;
  logic [WD_CNT_W-1:0]  wdLimit;
  logic                 limitValid;
  logic                 lfTick;
  logic                 service;
  logic                 lenHiWrite;
  logic [15:0]          newLen;

  hcwv_crc_if crcBus ();

  hcwv_crc_byte uCrcByte (
    .bus (crcBus)
  );

  // Engine always folds the byte returned by the tag memory
  assign crcBus.dataByte = memRdData;
  assign crcBus.crcIn    = crcRun_reg;

  // ***********************************************************************
  // Checksum registers and sequencer
  // ***********************************************************************
  assign lenHiWrite = regWrEn && (regAddr == ADDR_LEN_HI);
  assign newLen     = {regWrData, crcLen_reg[7:0]};

  // Two cycles per byte: the memory answers one cycle after the read
  always_comb begin
    crcState_next  = crcState_reg;
    startAddr_next = startAddr_reg;
    crcLen_next    = crcLen_reg;
    crcResult_next = crcResult_reg;
    crcRun_next    = crcRun_reg;
    bytesLeft_next = bytesLeft_reg;
    memAddr_next   = memAddr_reg;
    memRdEn_next   = 1'b0;
    crcDone_next   = 1'b0;
    if (regWrEn && regAddr == ADDR_START_LO) begin
      startAddr_next[7:0] = {regWrData[7:1], 1'b0};
    end
    if (regWrEn && regAddr == ADDR_START_HI) begin
      startAddr_next[15:8] = regWrData;
    end
    if (regWrEn && regAddr == ADDR_LEN_LO) begin
      crcLen_next[7:0] = {regWrData[7:1], 1'b0};
    end
    if (lenHiWrite) begin
      crcLen_next[15:8] = regWrData;
    end
    case (crcState_reg)
      CRC_IDLE: begin
        // A trigger during a run is dropped so the range stays coherent
        if (lenHiWrite) begin
          crcRun_next    = CRC_PRESET;
          bytesLeft_next = newLen;
          memAddr_next   = startAddr_reg;
          if (newLen == WORD_RESET) begin
            crcResult_next = CRC_PRESET;
            crcDone_next   = 1'b1;
          end else begin
            memRdEn_next  = 1'b1;
            crcState_next = CRC_FETCH;
          end
        end
      end
      CRC_FETCH: begin
        crcState_next = CRC_ACCUM;
      end
      CRC_ACCUM: begin
        crcRun_next    = crcBus.crcOut;
        bytesLeft_next = bytesLeft_reg - 16'h0001;
        if (bytesLeft_reg == 16'h0001) begin
          crcResult_next = crcBus.crcOut;
          crcDone_next   = 1'b1;
          crcState_next  = CRC_IDLE;
        end else begin
          memAddr_next  = memAddr_reg + 16'h0001;
          memRdEn_next  = 1'b1;
          crcState_next = CRC_FETCH;
        end
      end
      default: begin
        crcState_next = CRC_IDLE;
      end
    endcase
    // A watchdog reset returns the checksum registers to their reset state
    if (wdReset_reg) begin
      crcState_next  = CRC_IDLE;
      startAddr_next = WORD_RESET;
      crcLen_next    = WORD_RESET;
      crcResult_next = WORD_RESET;
      crcRun_next    = WORD_RESET;
      bytesLeft_next = WORD_RESET;
      memAddr_next   = WORD_RESET;
      memRdEn_next   = 1'b0;
      crcDone_next   = 1'b0;
    end
    crcActive_next = (crcState_next != CRC_IDLE);
  end

  // Register the checksum group
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      crcState_reg  <= CRC_IDLE;
      startAddr_reg <= WORD_RESET;
      crcLen_reg    <= WORD_RESET;
      crcResult_reg <= WORD_RESET;
      crcRun_reg    <= WORD_RESET;
      bytesLeft_reg <= WORD_RESET;
      memAddr_reg   <= WORD_RESET;
      memRdEn_reg   <= 1'b0;
      crcActive_reg <= 1'b0;
      crcDone_reg   <= 1'b0;
    end else begin
      crcState_reg  <= crcState_next;
      startAddr_reg <= startAddr_next;
      crcLen_reg    <= crcLen_next;
      crcResult_reg <= crcResult_next;
      crcRun_reg    <= crcRun_next;
      bytesLeft_reg <= bytesLeft_next;
      memAddr_reg   <= memAddr_next;
      memRdEn_reg   <= memRdEn_next;
      crcActive_reg <= crcActive_next;
      crcDone_reg   <= crcDone_next;
    end
  end

  // ***********************************************************************
  // Link watchdog
  // ***********************************************************************
  // Oscillator pin is asynchronous; only stages two and three feed logic
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      oscSync_reg <= 3'h0;
    end else begin
      oscSync_reg <= {oscSync_reg[1:0], lfOscPin};
    end
  end

  assign lfTick  = oscSync_reg[1] & ~oscSync_reg[2];
  assign service = xferDone & (~byteParityCheckMode | xferParityOk);

  // Period select; reserved codes never expire rather than guess a period
  always_comb begin
    wdLimit    = WD_CNT_W'(WD_TICKS_2S);
    limitValid = 1'b1;
    case (wdCtl_reg[WD_SEL_MSB:WD_SEL_LSB])
      WD_SEL_SHORT:  wdLimit = WD_CNT_W'(WD_TICKS_2S);
      WD_SEL_MEDIUM: wdLimit = WD_CNT_W'(WD_TICKS_32S);
      WD_SEL_LONG:   wdLimit = WD_CNT_W'(WD_TICKS_8M);
      default:       limitValid = 1'b0;
    endcase
  end

  // Count oscillator edges; a valid access restarts the period
  always_comb begin
    wdCtl_next   = wdCtl_reg;
    wdCount_next = wdCount_reg;
    wdReset_next = 1'b0;
    if (regWrEn && regAddr == ADDR_WD_LO) begin
      wdCtl_next = regWrData[3:0];
    end
    if (!wdCtl_reg[WD_EN_BIT] || service) begin
      wdCount_next = '0;
    end else if (lfTick && limitValid) begin
      if (wdCount_reg >= wdLimit - WD_CNT_W'(1)) begin
        wdCount_next = '0;
        wdReset_next = 1'b1;
      end else begin
        wdCount_next = wdCount_reg + WD_CNT_W'(1);
      end
    end
    if (wdReset_reg) begin
      wdCtl_next   = WD_CTL_RESET;
      wdCount_next = '0;
      wdReset_next = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wdCtl_reg   <= WD_CTL_RESET;
      wdCount_reg <= '0;
      wdReset_reg <= 1'b0;
    end else begin
      wdCtl_reg   <= wdCtl_next;
      wdCount_reg <= wdCount_next;
      wdReset_reg <= wdReset_next;
    end
  end

  // ***********************************************************************
  // Read path
  // ***********************************************************************
  // Unmapped byte addresses answer zero
  always_comb begin
    rdValid_next = regRdEn;
    rdData_next  = rdData_reg;
    if (regRdEn) begin
      case (regAddr)
        ADDR_VERSION_LO: rdData_next = FW_ID;
        ADDR_VERSION_HI: rdData_next = FW_REV;
        ADDR_WD_LO:      rdData_next = {4'h0, wdCtl_reg};
        ADDR_WD_HI:      rdData_next = 8'h00;
        ADDR_START_LO:   rdData_next = startAddr_reg[7:0];
        ADDR_START_HI:   rdData_next = startAddr_reg[15:8];
        ADDR_LEN_LO:     rdData_next = crcLen_reg[7:0];
        ADDR_LEN_HI:     rdData_next = crcLen_reg[15:8];
        ADDR_RESULT_LO:  rdData_next = crcResult_reg[7:0];
        ADDR_RESULT_HI:  rdData_next = crcResult_reg[15:8];
        default:         rdData_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rdData_reg  <= 8'h00;
      rdValid_reg <= 1'b0;
    end else begin
      rdData_reg  <= rdData_next;
      rdValid_reg <= rdValid_next;
    end
  end

  assign regRdData     = rdData_reg;
  assign regRdValid    = rdValid_reg;
  assign memAddr       = memAddr_reg;
  assign memRdEn       = memRdEn_reg;
  assign crcActive     = crcActive_reg;
  assign crcDone       = crcDone_reg;
  assign watchdogReset = wdReset_reg;

  // ***********************************************************************
  // Assertions
  // ***********************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  sequence s_launch;
    lenHiWrite && crcState_reg == CRC_IDLE && !wdReset_reg;
  endsequence

  sequence s_lastByte;
    crcState_reg == CRC_ACCUM && bytesLeft_reg == 16'h0001 && !wdReset_reg;
  endsequence

  property p_evenBounds;
    startAddr_reg[0] == 1'b0 && crcLen_reg[0] == 1'b0;
  endproperty
  a_evenBounds: assert property (p_evenBounds)
    else $error("checksum start or length is odd");

  property p_crcPreset;
    s_launch ##0 (newLen != WORD_RESET) |=> crcRun_reg == CRC_PRESET
      && memRdEn && memAddr == $past(startAddr_reg) ##1 !memRdEn;
  endproperty
  a_crcPreset: assert property (p_crcPreset)
    else $error("checksum run not preset or fetch wrong");

  property p_launch;
    s_launch ##0 (newLen != WORD_RESET) |=> crcActive;
  endproperty
  a_launch: assert property (p_launch)
    else $error("length high write did not start a run");

  property p_emptyRun;
    s_launch ##0 (newLen == WORD_RESET) |=> crcDone && !crcActive
      && crcResult_reg == CRC_PRESET;
  endproperty
  a_emptyRun: assert property (p_emptyRun)
    else $error("empty run did not finish at once");

  property p_done;
    s_lastByte |=> crcDone && !crcActive
      && crcResult_reg == $past(crcBus.crcOut);
  endproperty
  a_done: assert property (p_done)
    else $error("run end did not flag or load result");

  property p_wdFire;
    wdCtl_reg[WD_EN_BIT] && !service && lfTick && limitValid
      && !wdReset_reg && wdCount_reg == wdLimit - WD_CNT_W'(1)
      |=> watchdogReset ##1 !watchdogReset && wdCtl_reg == WD_CTL_RESET;
  endproperty
  a_wdFire: assert property (p_wdFire)
    else $error("watchdog did not reset on expiry");

  property p_badParity;
    byteParityCheckMode && xferDone && !xferParityOk && !lfTick
      && wdCtl_reg[WD_EN_BIT] && !wdReset_reg
      |=> wdCount_reg == $past(wdCount_reg);
  endproperty
  a_badParity: assert property (p_badParity)
    else $error("failed parity transfer served the watchdog");

  property p_disabled;
    !wdCtl_reg[WD_EN_BIT] |=> wdCount_reg == '0 && !watchdogReset;
  endproperty
  a_disabled: assert property (p_disabled)
    else $error("disabled watchdog is counting");

  property p_period;
    (wdCtl_reg[3:1] == WD_SEL_LONG) |-> wdLimit == WD_CNT_W'(WD_TICKS_8M)
      && limitValid;
  endproperty
  a_period: assert property (p_period)
    else $error("long period code selects wrong count");

  property p_version;
    regRdEn && regAddr == ADDR_VERSION_LO |=> regRdValid
      && regRdData == FW_ID;
  endproperty
  a_version: assert property (p_version)
    else $error("version low byte read wrong");

  property p_wdUpperZero;
    regRdEn && (regAddr == ADDR_WD_HI || regAddr == ADDR_WD_LO)
      |=> regRdData[7:4] == 4'h0;
  endproperty
  a_wdUpperZero: assert property (p_wdUpperZero)
    else $error("reserved watchdog bits read nonzero");

endmodule

// ### testbench/hcwv_mem_model.sv
// Tag memory model that answers the checksum engine's byte reads
`timescale 1ns/1ps
module hcwv_mem_model (
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic [15:0] memAddr,
  input  wire logic        memRdEn,
  output logic      [7:0]  memRdData
);
  // ***********************************************************************
  // Read port, one cycle latency
  // ***********************************************************************
  // Outside the answer cycle the byte flips each cycle, so an early or
  // late sample by the engine shows up as a wrong checksum
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      memRdData <= 8'hA5;
    end else if (memRdEn) begin
      memRdData <= memAddr[7:0] ^ memAddr[15:8] ^ 8'h3C;
    end else begin
      memRdData <= ~memRdData;
    end
  end
endmodule

// ### testbench/tb.sv
// Self-checking bench for the host checksum, watchdog and version block
`timescale 1ns/1ps
module tb;
  import hcwv_pkg::*;
  localparam logic [7:0] ID_VAL  = 8'h5A; // Arbitrary identity value
  localparam logic [7:0] REV_VAL = 8'h03; // Arbitrary revision value
  localparam int         OSC_CYC = 391;   // Clock cycles per oscillator period

  logic        mclk;
  logic        rstn;
  logic [15:0] regAddr;
  logic [7:0]  regWrData;
  logic        regWrEn;
  logic        regRdEn;
  logic [7:0]  regRdData;
  logic        regRdValid;
  logic        xferDone;
  logic        xferParityOk;
  logic        byteParityCheckMode;
  logic        lfOscPin;
  logic [15:0] memAddr;
  logic        memRdEn;
  logic [7:0]  memRdData;
  logic        crcActive;
  logic        crcDone;
  logic        watchdogReset;
  logic [2:0]  sel;
  int          rdCount;
  int          doneCount;
  int          wdFires;
  int          oscRises;
  int          numErrors;
  int          totalChecks;
  int          i;
  int          f0;
  int          o0;
  int          n;
  int          lim;

  // Short watchdog limits keep the run brief
  hcwv_top #(.FW_ID(ID_VAL), .FW_REV(REV_VAL), .WD_TICKS_2S(4),
             .WD_TICKS_32S(6), .WD_TICKS_8M(8)) dut_u (
    .mclk                (mclk),
    .rstn                (rstn),
    .regAddr             (regAddr),
    .regWrData           (regWrData),
    .regWrEn             (regWrEn),
    .regRdEn             (regRdEn),
    .regRdData           (regRdData),
    .regRdValid          (regRdValid),
    .xferDone            (xferDone),
    .xferParityOk        (xferParityOk),
    .byteParityCheckMode (byteParityCheckMode),
    .lfOscPin            (lfOscPin),
    .memAddr             (memAddr),
    .memRdEn             (memRdEn),
    .memRdData           (memRdData),
    .crcActive           (crcActive),
    .crcDone             (crcDone),
    .watchdogReset       (watchdogReset)
  );

  hcwv_mem_model mem_u (
    .mclk      (mclk),
    .rstn      (rstn),
    .memAddr   (memAddr),
    .memRdEn   (memRdEn),
    .memRdData (memRdData)
  );

  // ***********************************************************************
  // Clocks and event counters
  // ***********************************************************************
  // Oscillator phase is unrelated to the main clock on purpose
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    lfOscPin = 1'b0;
    #777;
    forever #1953 lfOscPin = ~lfOscPin;
  end
  // Pulses are counted where the design launches them
  always @(posedge mclk) begin
    if (memRdEn === 1'b1) rdCount++;
    if (crcDone === 1'b1) doneCount++;
    if (watchdogReset === 1'b1) wdFires++;
  end
  always @(posedge lfOscPin) oscRises++;

  // ***********************************************************************
  // Helpers
  // ***********************************************************************
  function automatic logic [7:0] memByte(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3C;
  endfunction

  // Bitwise reference, most significant bit first, no final inversion
  function automatic logic [15:0] crcRef(input logic [15:0] s,
                                         input logic [15:0] len);
    logic [15:0] c;
    logic [7:0]  b;
    c = 16'hFFFF;
    for (int k = 0; k < len; k++) begin
      b = memByte(s + 16'(k));
      for (int j = 7; j >= 0; j--) begin
        c = {c[14:0], 1'b0} ^ ((c[15] ^ b[j]) ? 16'h1021 : 16'h0000);
      end
    end
    return c;
  endfunction

  task automatic endSim();
    $display("Checks %0d, errors %0d", totalChecks, numErrors);
    if (numErrors == 0 && totalChecks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      numErrors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic regWrite(input logic [15:0] a, input logic [7:0] d);
    @(negedge mclk);
    regAddr   = a;
    regWrData = d;
    regWrEn   = 1'b1;
    @(negedge mclk);
    regWrEn   = 1'b0;
  endtask

  // Answer is registered on the taking edge and checked one cycle after the request is driven
  task automatic readCheck(input logic [15:0] a, input logic [7:0] exp);
    @(negedge mclk);
    regAddr = a;
    regRdEn = 1'b1;
    @(negedge mclk);
    regRdEn = 1'b0;
    check(16'(regRdValid), 16'h0001);
    check({8'h00, regRdData}, {8'h00, exp});
    // Valid pulse stands one cycle only, data holds until the next read
    @(negedge mclk);
    check(16'(regRdValid), 16'h0000);
    check({8'h00, regRdData}, {8'h00, exp});
  endtask

  task automatic xfer(input logic ok);
    @(negedge mclk);
    xferDone     = 1'b1;
    xferParityOk = ok;
    @(negedge mclk);
    xferDone     = 1'b0;
  endtask

  // Bounded waits; a wait that runs out ends the run as a mismatch
  task automatic waitCount(ref int cnt, input int c0, input int bound);
    for (int j = 0; j < bound && cnt == c0; j++) @(negedge mclk);
    if (cnt == c0) begin
      numErrors++;
      endSim();
    end
  endtask

  task automatic runCrc(input logic [15:0] s, input logic [15:0] len);
    logic [15:0] se;
    logic [15:0] le;
    logic [15:0] exp;
    int          r0;
    int          d0;
    se  = {s[15:1], 1'b0};
    le  = {len[15:1], 1'b0};
    exp = crcRef(se, le);
    r0  = rdCount;
    d0  = doneCount;
    regWrite(ADDR_START_LO, s[7:0]);
    regWrite(ADDR_START_HI, s[15:8]);
    regWrite(ADDR_LEN_LO, len[7:0]);
    regWrite(ADDR_LEN_HI, len[15:8]);
    if (le != 16'h0000) begin
      check(16'(crcActive), 16'h0001);
      check(memAddr, se);
      regWrite(ADDR_LEN_HI, len[15:8]);
    end
    waitCount(doneCount, d0, 1200);
    check(16'(crcActive), 16'h0000);
    check(16'(rdCount - r0), le);
    readCheck(ADDR_START_LO, se[7:0]);
    readCheck(ADDR_RESULT_LO, exp[7:0]);
    readCheck(ADDR_RESULT_HI, exp[15:8]);
  endtask

  // ***********************************************************************
  // Main sequence
  // ***********************************************************************
  initial begin
    rstn = 1'b0;
    regAddr = 16'h0000;
    regWrData = 8'h00;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    xferDone = 1'b0;
    xferParityOk = 1'b0;
    byteParityCheckMode = 1'b0;
    repeat (2) @(negedge mclk);
    rstn = 1'b1;
    readCheck(ADDR_VERSION_LO, ID_VAL);
    readCheck(ADDR_VERSION_HI, REV_VAL);
    readCheck(ADDR_WD_LO, 8'h00);
    readCheck(ADDR_WD_HI, 8'h00);
    regWrite(ADDR_VERSION_LO, 8'hC3);
    regWrite(ADDR_WD_HI, 8'hFF);
    regWrite(16'hFFFC, 8'hFF);
    regWrite(ADDR_WD_LO, 8'hFE);
    readCheck(ADDR_VERSION_LO, ID_VAL);
    readCheck(ADDR_WD_HI, 8'h00);
    readCheck(16'hFFFC, 8'h00);
    readCheck(ADDR_WD_LO, 8'h0E);
    regWrite(ADDR_WD_LO, 8'h00);
    // Odd start and length, a long run and an empty run
    runCrc(16'h0011, 16'h0005);
    runCrc(16'h0FFE, 16'h0102);
    runCrc(16'h0040, 16'h0000);
    // Each valid period code expires after its own tick count
    for (i = 0; i < 3; i++) begin
      sel = 3'(i);
      lim = 4 + 2 * i;
      f0  = wdFires;
      o0  = oscRises;
      regWrite(ADDR_WD_LO, {4'h0, sel, 1'b1});
      waitCount(wdFires, f0, (lim + 2) * OSC_CYC);
      n = oscRises - o0;
      check(16'(n >= lim - 1 && n <= lim), 16'h0001);
      readCheck(ADDR_WD_LO, 8'h00);
      // Expiry resets the checksum registers, checksum result included
      readCheck(ADDR_RESULT_HI, 8'h00);
    end
    // A reserved code must never expire
    f0 = wdFires;
    regWrite(ADDR_WD_LO, 8'h07);
    repeat (12 * OSC_CYC) @(negedge mclk);
    check(16'(wdFires - f0), 16'h0000);
    // Service with and without parity mode; a bad transfer is no service
    for (i = 0; i < 3; i++) begin
      f0 = wdFires;
      byteParityCheckMode = (i > 0);
      regWrite(ADDR_WD_LO, 8'h01);
      repeat (5) begin
        repeat (2 * OSC_CYC) @(negedge mclk);
        xfer(i == 1);
      end
      check(16'(wdFires - f0), 16'(i == 2));
    end
    endSim();
  end
endmodule
